/* core/i2csw_consts.svh */
// Constants for the four-channel bus switch / multiplexer and its master
`ifndef I2CSW_CONSTS_SVH
`define I2CSW_CONSTS_SVH

// Fixed upper address bits for the two-strap and three-strap variants
`define I2CSW_FIXED5 5'h1c
`define I2CSW_FIXED4 4'he

// Direction bit following the seven address bits
`define I2CSW_RW_WRITE 1'b0
`define I2CSW_RW_READ 1'b1

// Register layout: selection field low, interrupt status high
`define I2CSW_SEL_W 4
`define I2CSW_IRQ_LSB 4
`define I2CSW_MUX_EN_BIT 2

// Bit count of one byte, without its acknowledge
`define I2CSW_BYTE_BITS 4'h8

// Master timing: system clock period and bus clock period in ns
`define I2CSW_CLK_NS 25
`define I2CSW_SCL_NS 10000
`define I2CSW_QTR_CYC ((`I2CSW_SCL_NS / 4) / `I2CSW_CLK_NS)

`endif

/* core/i2csw_pkg.sv */
// Types shared by the switch device and its bus master
package i2csw_pkg;

  // Device variants: switch with two straps and interrupts, switch with
  // three straps and no interrupts, multiplexer with three straps and interrupts
  typedef enum logic [1:0] {
    I2CSW_SW2A,
    I2CSW_SW3A,
    I2CSW_MUX3A
  } i2csw_variant_t;

  // Slave engine states
  typedef enum logic [2:0] {
    I2CSW_D_IDLE,
    I2CSW_D_ADDR,
    I2CSW_D_AACK,
    I2CSW_D_WDATA,
    I2CSW_D_WACK,
    I2CSW_D_RDATA,
    I2CSW_D_RACK
  } i2csw_dstate_t;

  // Master engine states
  typedef enum logic [1:0] {
    I2CSW_H_IDLE,
    I2CSW_H_START,
    I2CSW_H_BIT,
    I2CSW_H_STOP
  } i2csw_hstate_t;

endpackage

/* core/i2csw_if.sv */
// Two-wire main bus between master and switch device
`timescale 1ns/1ps
interface i2csw_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires: low while any party pulls
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport host(output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport dev(output s_sda_oe, input scl, input sda);
endinterface

/* core/i2csw_host.sv */
// Bus master end: one-byte write or read transaction to the switch device
`timescale 1ns/1ps
`include "i2csw_consts.svh"
module i2csw_host #(
  parameter int QTR_CYC = `I2CSW_QTR_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  i2csw_if.host bus,
  input wire logic i_req,
  input wire logic i_rw,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  import i2csw_pkg::*;

  i2csw_pkg::i2csw_hstate_t state_ff, nxt_state;
  logic [15:0] qcnt_ff, nxt_qcnt;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bitn_ff, nxt_bitn;
  logic byten_ff, nxt_byten;
  logic [8:0] tx_ff, nxt_tx;
  logic [8:0] rx_ff, nxt_rx;
  logic rw_ff, nxt_rw;
  logic [7:0] wdata_ff, nxt_wdata;
  logic scl_oe_ff, nxt_scl_oe;
  logic sda_oe_ff, nxt_sda_oe;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic nack_ff, nxt_nack;
  logic [7:0] rdata_ff, nxt_rdata;
  logic sda_s1_ff, sda_s2_ff;
  logic tick;

  assign tick = (qcnt_ff == 16'(QTR_CYC - 1));

  // Bus data pin is asynchronous here: two flops before use
  always_ff @(posedge i_clk) begin
    sda_s1_ff <= bus.sda;
    sda_s2_ff <= sda_s1_ff;
  end

  // Quarter-period sequencer driving clock and data
  always_comb begin
    nxt_state = state_ff;
    nxt_qcnt = qcnt_ff;
    nxt_ph = ph_ff;
    nxt_bitn = bitn_ff;
    nxt_byten = byten_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_rw = rw_ff;
    nxt_wdata = wdata_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_nack = nack_ff;
    nxt_rdata = rdata_ff;
    if (state_ff != I2CSW_H_IDLE) begin
      nxt_qcnt = tick ? 16'h0000 : qcnt_ff + 16'h0001;
      if (tick) begin
        nxt_ph = ph_ff + 2'h1;
      end
    end
    unique case (state_ff)
      I2CSW_H_IDLE: begin
        if (i_req) begin
          nxt_state = I2CSW_H_START;
          nxt_tx = {i_addr, i_rw, 1'b1};
          nxt_rw = i_rw;
          nxt_wdata = i_wdata;
          nxt_busy = 1'b1;
          nxt_nack = 1'b0;
          nxt_qcnt = 16'h0000;
          nxt_ph = 2'h0;
          nxt_byten = 1'b0;
        end
      end
      I2CSW_H_START: begin
        if (tick) begin
          if (ph_ff == 2'h1) nxt_sda_oe = 1'b1;
          if (ph_ff == 2'h2) nxt_scl_oe = 1'b1;
          if (ph_ff == 2'h3) begin
            nxt_state = I2CSW_H_BIT;
            nxt_bitn = 4'h0;
          end
        end
      end
      I2CSW_H_BIT: begin
        if (tick) begin
          unique case (ph_ff)
            2'h0: nxt_sda_oe = ~tx_ff[8];
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_rx = {rx_ff[7:0], sda_s2_ff};
            2'h3: begin
              nxt_scl_oe = 1'b1;
              nxt_tx = {tx_ff[7:0], 1'b1};
              nxt_bitn = bitn_ff + 4'h1;
              if (bitn_ff == `I2CSW_BYTE_BITS) begin
                nxt_bitn = 4'h0;
                if (!byten_ff) begin
                  // Data byte or read byte follows the address
                  nxt_byten = 1'b1;
                  nxt_tx = rw_ff ? 9'h1ff : {wdata_ff, 1'b1};
                  if (rx_ff[0]) begin
                    nxt_nack = 1'b1;
                    nxt_state = I2CSW_H_STOP;
                  end
                end else begin
                  nxt_state = I2CSW_H_STOP;
                  if (rw_ff) nxt_rdata = rx_ff[8:1];
                  else nxt_nack = rx_ff[0];
                end
              end
            end
          endcase
        end
      end
      I2CSW_H_STOP: begin
        if (tick) begin
          if (ph_ff == 2'h0) nxt_sda_oe = 1'b1;
          if (ph_ff == 2'h1) nxt_scl_oe = 1'b0;
          if (ph_ff == 2'h2) nxt_sda_oe = 1'b0;
          if (ph_ff == 2'h3) begin
            nxt_state = I2CSW_H_IDLE;
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
          end
        end
      end
    endcase
  end

  // Master state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= I2CSW_H_IDLE;
      qcnt_ff <= 16'h0000;
      ph_ff <= 2'h0;
      bitn_ff <= 4'h0;
      byten_ff <= 1'b0;
      tx_ff <= 9'h1ff;
      rx_ff <= 9'h000;
      rw_ff <= 1'b0;
      wdata_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      qcnt_ff <= nxt_qcnt;
      ph_ff <= nxt_ph;
      bitn_ff <= nxt_bitn;
      byten_ff <= nxt_byten;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      rw_ff <= nxt_rw;
      wdata_ff <= nxt_wdata;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_nack = nack_ff;
  assign o_rdata = rdata_ff;
endmodule

/* core/i2csw_dev.sv */
// Switch device end: two-wire slave, selection register and interrupt merge
//
// Contract
// - two-strap variant address is 11100 plus straps
// - three-strap variants address is 1110 plus straps
// - address shifted most significant bit first
// - straps stable while their bit is compared
// - after address ack, one or more bytes written or read
// - write keeps low 3 or 4 bits
// - several bytes written, last byte kept
// - new selection takes effect at STOP
// - switch bits connect channels independently, default off
// - mux bit 2 enables, bits 1:0 choose
// - channel pair idle high when connected
// - interrupt output low while any input low
// - register bits 4 to 7 show inputs
// - inputs not latched; downstream releases them
// - interrupt reported whether channel selected or not
// - interrupt levels sampled when read performed
// - master reads, selects channel, then polls
// - reset input returns register and engine default
// - power-on leaves register zero, channels off; code clears them only through i_srst, with no power-on clear
// - direction bit 0 write, 1 read; ack low
// - status bit reads 1 when input asserted
`timescale 1ns/1ps
`include "i2csw_consts.svh"
module i2csw_dev #(
  parameter i2csw_pkg::i2csw_variant_t VARIANT = i2csw_pkg::I2CSW_SW2A
) (
  input wire logic i_link_clk,
  input wire logic i_srst,
  i2csw_if.dev bus,
  input wire logic [2:0] i_addr_strap,
  input wire logic [3:0] i_irq_n,
  output logic [3:0] o_chan_en,
  output logic o_int_oe
);
  import i2csw_pkg::*;

  localparam bit IS_MUX = (VARIANT == I2CSW_MUX3A);
  localparam bit HAS_IRQ = (VARIANT != I2CSW_SW3A);

  i2csw_pkg::i2csw_dstate_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sr_ff, nxt_sr;
  logic rw_ff, nxt_rw;
  logic mack_ff, nxt_mack;
  logic sda_oe_ff, nxt_sda_oe;
  logic [3:0] sel_ff, nxt_sel;
  logic [3:0] pend_ff, nxt_pend;
  logic pend_v_ff, nxt_pend_v;
  logic [3:0] chan_en_ff, nxt_chan_en;
  logic int_oe_ff, nxt_int_oe;
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic [2:0] strap_s1_ff, strap_s2_ff;
  logic [3:0] irq_s1_ff, irq_s2_ff;
  logic start_det, stop_det, scl_rise, scl_fall;
  logic [7:0] rd_byte;

  // Address compare against fixed bits and the live straps
  function automatic logic addr_match(input logic [6:0] a, input logic [2:0] strap);
    if (VARIANT == I2CSW_SW2A) begin
      addr_match = (a == {`I2CSW_FIXED5, strap[1:0]});
    end else begin
      addr_match = (a == {`I2CSW_FIXED4, strap});
    end
  endfunction

  // Selection field to connected channels
  function automatic logic [3:0] chan_decode(input logic [3:0] sel);
    if (IS_MUX) begin
      chan_decode = 4'h0;
      if (sel[`I2CSW_MUX_EN_BIT]) begin
        chan_decode = 4'h1 << sel[1:0];
      end
    end else begin
      chan_decode = sel;
    end
  endfunction

  // Pins come from outside the link domain: two flops each, a third for edges
  always_ff @(posedge i_link_clk) begin
    scl_s1_ff <= bus.scl;
    scl_s2_ff <= scl_s1_ff;
    scl_s3_ff <= scl_s2_ff;
    sda_s1_ff <= bus.sda;
    sda_s2_ff <= sda_s1_ff;
    sda_s3_ff <= sda_s2_ff;
    strap_s1_ff <= i_addr_strap;
    strap_s2_ff <= strap_s1_ff;
    irq_s1_ff <= i_irq_n;
    irq_s2_ff <= irq_s1_ff;
  end

  // Bus conditions seen on the synchronised lines
  assign start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
  assign scl_rise = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall = ~scl_s2_ff & scl_s3_ff;

  // Read byte: live interrupt levels high, stored selection low
  assign rd_byte = {(HAS_IRQ ? ~irq_s2_ff : 4'h0), sel_ff};

  // Slave engine, selection register and interrupt merge
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sr = sr_ff;
    nxt_rw = rw_ff;
    nxt_mack = mack_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_sel = sel_ff;
    nxt_pend = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_chan_en = chan_en_ff;
    // Any input low pulls the shared line; channel selection plays no part
    nxt_int_oe = HAS_IRQ & ~(&irq_s2_ff);
    if (start_det) begin
      nxt_state = I2CSW_D_ADDR;
      nxt_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = I2CSW_D_IDLE;
      nxt_sda_oe = 1'b0;
      // Commit only at STOP, when both main lines are high and idle
      if (pend_v_ff) begin
        nxt_sel = pend_ff;
        nxt_chan_en = chan_decode(pend_ff);
        nxt_pend_v = 1'b0;
      end
    end else begin
      unique case (state_ff)
        I2CSW_D_IDLE: begin
        end
        I2CSW_D_ADDR: begin
          if (scl_rise) begin
            nxt_sr = {sr_ff[6:0], sda_s2_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `I2CSW_BYTE_BITS) begin
            if (addr_match(sr_ff[7:1], strap_s2_ff)) begin
              nxt_state = I2CSW_D_AACK;
              nxt_sda_oe = 1'b1;
              nxt_rw = (sr_ff[0] == `I2CSW_RW_READ);
            end else begin
              nxt_state = I2CSW_D_IDLE;
            end
          end
        end
        I2CSW_D_AACK: begin
          if (scl_fall) begin
            nxt_cnt = 4'h0;
            if (rw_ff) begin
              // Interrupt levels caught here, as the read begins
              nxt_state = I2CSW_D_RDATA;
              nxt_sr = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
            end else begin
              nxt_state = I2CSW_D_WDATA;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        I2CSW_D_WDATA: begin
          if (scl_rise) begin
            nxt_sr = {sr_ff[6:0], sda_s2_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `I2CSW_BYTE_BITS) begin
            // Each new byte overwrites the pending one
            nxt_pend = IS_MUX ? {1'b0, sr_ff[2:0]} : sr_ff[3:0];
            nxt_pend_v = 1'b1;
            nxt_state = I2CSW_D_WACK;
            nxt_sda_oe = 1'b1;
          end
        end
        I2CSW_D_WACK: begin
          if (scl_fall) begin
            nxt_state = I2CSW_D_WDATA;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
          end
        end
        I2CSW_D_RDATA: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (cnt_ff == `I2CSW_BYTE_BITS) begin
              nxt_state = I2CSW_D_RACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sr = {sr_ff[6:0], 1'b0};
              nxt_sda_oe = ~sr_ff[6];
            end
          end
        end
        I2CSW_D_RACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_s2_ff;
          end else if (scl_fall) begin
            if (mack_ff) begin
              // Master asked for more: fresh sample again
              nxt_state = I2CSW_D_RDATA;
              nxt_sr = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
              nxt_cnt = 4'h0;
            end else begin
              nxt_state = I2CSW_D_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Reset pin clears register and engine; there is no separate power-on clear
  always_ff @(posedge i_link_clk) begin
    if (i_srst) begin
      state_ff <= I2CSW_D_IDLE;
      cnt_ff <= 4'h0;
      sr_ff <= 8'h00;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sel_ff <= 4'h0;
      pend_ff <= 4'h0;
      pend_v_ff <= 1'b0;
      chan_en_ff <= 4'h0;
      int_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sr_ff <= nxt_sr;
      rw_ff <= nxt_rw;
      mack_ff <= nxt_mack;
      sda_oe_ff <= nxt_sda_oe;
      sel_ff <= nxt_sel;
      pend_ff <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
      chan_en_ff <= nxt_chan_en;
      int_oe_ff <= nxt_int_oe;
    end
  end

  assign bus.s_sda_oe = sda_oe_ff;
  assign o_chan_en = chan_en_ff;
  assign o_int_oe = int_oe_ff;
endmodule

/* sim/i2csw_monitor.sv */
// Checker of the main bus and the device pins of the switch link
`timescale 1ns/1ps
module i2csw_monitor (
  input wire logic i_link_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_sda_oe,
  input wire logic [3:0] i_irq_n,
  input wire logic [3:0] i_chan_en,
  input wire logic i_int_oe
);
  logic sda_ff;
  logic nxt_sda;
  logic [3:0] gap_ff;
  logic [3:0] nxt_gap;

  // Link cycles since the last STOP, saturating
  always_comb begin
    nxt_sda = i_sda;
    nxt_gap = gap_ff + {3'h0, gap_ff != 4'hf};
    if (i_srst) begin
      nxt_gap = 4'hf;
    end else if (i_scl && i_sda && !sda_ff) begin
      nxt_gap = 4'h0;
    end
  end

  // Helper registers
  always_ff @(posedge i_link_clk) begin
    sda_ff <= nxt_sda;
    gap_ff <= nxt_gap;
  end

  default clocking cb @(posedge i_link_clk); endclocking

  sequence s_stop;
    i_scl && i_sda && !sda_ff;
  endsequence
  sequence s_drive_start;
    $rose(i_sda_oe);
  endsequence

  a_sel_at_stop: assert property (disable iff (i_srst)
    $changed(i_chan_en) |-> gap_ff < 4'ha) else $error("selection moved without STOP");
  a_int_any_low: assert property (disable iff (i_srst)
    (!(&i_irq_n))[*5] |-> i_int_oe) else $error("interrupt output not pulled");
  a_int_all_high: assert property (disable iff (i_srst)
    (&i_irq_n)[*5] |-> !i_int_oe) else $error("interrupt output not released");
  a_drive_scl_low: assert property (disable iff (i_srst)
    s_drive_start |-> !i_scl) else $error("device pulled data while clock high");
  a_drive_holds: assert property (disable iff (i_srst)
    s_drive_start |-> i_sda_oe[*8]) else $error("device bit too short");
  a_data_stable: assert property (disable iff (i_srst)
    i_scl && $past(i_scl) |-> $stable(i_sda_oe)) else $error("device data moved in clock high");
  a_stop_quiet: assert property (disable iff (i_srst)
    s_stop |=> (!i_sda_oe)[*8]) else $error("device drove after STOP");
  a_reset_clears: assert property (disable iff (1'b0)
    i_srst |=> i_chan_en == 4'h0 && !i_int_oe) else $error("reset left outputs set");
endmodule

/* sim/i2c_channel_switch_mux_bench.sv */
// Bench joining the bus master and the switch device, with a reference model
`timescale 1ns/1ps
module i2c_channel_switch_mux_bench;
  import i2csw_pkg::*;
  localparam int QTR = 24;
  logic i_clk = 1'b0;
  logic link_clk = 1'b0;
  logic i_srst = 1'b1;
  logic lrst = 1'b1;
  logic req = 1'b0;
  logic rw = 1'b0;
  logic [6:0] addr = 7'h70;
  logic [7:0] wdata = 8'h00;
  logic busy, done, nack;
  logic [7:0] rdata;
  logic [2:0] strap = 3'h0;
  logic [3:0] irq_n = 4'hf;
  logic [3:0] chan_en;
  logic int_oe;
  logic [7:0] rnd = 8'h43;
  int n_fail = 0;
  int num_checks = 0;
  int sel_m = 0;

  // Clocks: system 25 ns, link 125 ns with an odd phase
  initial forever #12.5 i_clk = ~i_clk;
  initial begin
    #7.3;
    forever #62.5 link_clk = ~link_clk;
  end

  i2csw_if bus ();
  i2csw_host #(.QTR_CYC(QTR)) u_i2csw_host (.i_clk(i_clk), .i_srst(i_srst), .bus(bus),
    .i_req(req), .i_rw(rw), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_nack(nack), .o_rdata(rdata));
  i2csw_dev #(.VARIANT(I2CSW_SW2A)) u_i2csw_dev (.i_link_clk(link_clk), .i_srst(lrst),
    .bus(bus), .i_addr_strap(strap), .i_irq_n(irq_n), .o_chan_en(chan_en), .o_int_oe(int_oe));
  i2csw_monitor u_i2csw_monitor (.i_link_clk(link_clk), .i_srst(lrst), .i_scl(bus.scl),
    .i_sda(bus.sda), .i_sda_oe(bus.s_sda_oe), .i_irq_n(irq_n), .i_chan_en(chan_en),
    .i_int_oe(int_oe));

  // Pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One master transaction, waiting for its done pulse
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    rw = r;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge i_clk);
    req = 1'b0;
    chk({7'h0, busy}, 8'h01);
    while (done !== 1'b1 && n < 100 * QTR) begin
      @(negedge i_clk);
      n++;
    end
    chk({6'h0, busy, done}, 8'h01);
  endtask

  // Let k link cycles pass, then return at a system falling edge
  task automatic lwait(input int k);
    repeat (k) @(posedge link_clk);
    @(negedge i_clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(posedge link_clk);
    @(negedge i_clk);
    lrst = 1'b0;
    lwait(6);
    chk({4'h0, chan_en}, 8'h00);
    xfer(1'b1, {5'h1c, strap[1:0]}, 8'h00);
    chk(rdata, 8'h00);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      strap = rnd[7:5];
      rnd = lfsr(rnd);
      lwait(4);
      xfer(1'b0, {5'h1c, strap[1:0]}, rnd);
      chk({7'h0, nack}, 8'h00);
      sel_m = rnd & 8'h0f;
      lwait(8);
      chk({4'h0, chan_en}, 8'(sel_m));
      rnd = lfsr(rnd);
      irq_n = rnd[3:0];
      lwait(6);
      chk({7'h0, int_oe}, {7'h0, ~&irq_n});
      xfer(1'b1, {5'h1c, strap[1:0]}, 8'h00);
      chk(rdata, {~irq_n, 4'(sel_m)});
    end
    $display("test select_and_status done");
    xfer(1'b0, {5'h1c, ~strap[1:0]}, {4'h0, ~4'(sel_m)});
    chk({7'h0, nack}, 8'h01);
    xfer(1'b0, {5'h1d, strap[1:0]}, {4'h0, ~4'(sel_m)});
    chk({7'h0, nack}, 8'h01);
    lwait(8);
    chk({4'h0, chan_en}, 8'(sel_m));
    $display("test foreign_address done");
    // Service: read status, inputs released mid-read, then select the flagged channel
    irq_n = 4'hb;
    lwait(6);
    fork
      xfer(1'b1, {5'h1c, strap[1:0]}, 8'h00);
      begin
        lwait(240);
        irq_n = 4'hf;
      end
    join
    chk(rdata, {4'h4, 4'(sel_m)});
    sel_m = 4;
    xfer(1'b0, {5'h1c, strap[1:0]}, 8'(sel_m));
    lwait(8);
    chk({4'h0, chan_en}, 8'(sel_m));
    chk({7'h0, int_oe}, 8'h00);
    $display("test service done");
    lrst = 1'b1;
    lwait(2);
    lrst = 1'b0;
    sel_m = 0;
    irq_n = 4'hf;
    lwait(6);
    chk({4'h0, chan_en}, 8'h00);
    xfer(1'b1, {5'h1c, strap[1:0]}, 8'h00);
    chk(rdata, 8'h00);
    $display("test midrun_reset done");
    close_out();
  end

  // Watchdog sized well past the expected run
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
endmodule
